/* File: common/cmogl_pkg.sv */
package cmogl_pkg;
    // Device shape
    localparam int NUM_OUT = 4;
    localparam int NUM_IN = 2;
    localparam int APB_AW = 8;
    localparam int APB_DW = 32;

    // Timing: loss is declared after this long without a selected-input edge
    localparam int CLK_PERIOD_NS = 40;
    localparam int LOS_TIME_NS = 640;
    localparam int LOS_CYC = (LOS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Edges of the selected input needed before it counts as present
    localparam int VALID_EDGES = 4;

    // Register byte addresses
    localparam logic [APB_AW-1:0] ADDR_OUT_EN = 8'h00;
    localparam logic [APB_AW-1:0] ADDR_IN_CFG = 8'h04;
    localparam logic [APB_AW-1:0] ADDR_LOSS_EVT = 8'h08;
    localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h0c;

    // Input config field layout: per input, termination then self-bias
    localparam int CFG_TERM0 = 0;
    localparam int CFG_BIAS0 = 1;
    localparam int CFG_STRIDE = 2;
    // Loss event flags, input 0 at bit 1, input 1 at bit 2
    localparam int EVT_BIT0 = 1;
    // Status fields
    localparam int STAT_LOSS = 0;
    localparam int STAT_SEL = 1;

    // Reset values
    localparam logic OUT_EN_RST = 1'b1;
    localparam logic CFG_RST = 1'b0;
    localparam logic EVT_RST = 1'b0;

    // Loss detector state
    typedef enum logic [1:0] {
        CMOGL_WAIT = 2'b00,
        CMOGL_VALID = 2'b01,
        CMOGL_LOST = 2'b10
    } cmogl_los_e;
endpackage

/* File: common/cmogl_gate_if.sv */
`timescale 1ns/1ps
interface cmogl_gate_if;
    logic clk_lvl;
    logic rise;
    logic fall;
    logic en;
    logic park;
    logic out_true;
    logic out_comp;

    modport ctrl (output clk_lvl, output rise, output fall, output en, output park,
                  input out_true, input out_comp);
    modport gate (input clk_lvl, input rise, input fall, input en, input park,
                  output out_true, output out_comp);
endinterface

/* File: hdl/cmogl_out_gate.sv */
`timescale 1ns/1ps
module cmogl_out_gate (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    cmogl_gate_if.gate g
);
    import cmogl_pkg::*;

    logic on_q;
    logic on_d;
    logic true_q;
    logic comp_q;

    // Gate opens only on a rising edge and, unless parked, closes only on a falling edge,
    // so outside park no shortened high or low phase reaches the pin
    assign on_d = g.park ? 1'b0 :
                  (g.rise && g.en) ? 1'b1 :
                  (g.fall && !g.en) ? 1'b0 : on_q;

    // Gate state and registered differential pair
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            on_q <= 1'b0;
            true_q <= 1'b0;
            comp_q <= 1'b0;
        end else begin
            on_q <= on_d;
            true_q <= on_d & g.clk_lvl;
            comp_q <= on_d & ~g.clk_lvl;              // Low/low while closed
        end
    end

    assign g.out_true = true_q;
    assign g.out_comp = comp_q;

    park_low_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        g.park |=> !true_q && !comp_q)
        else $error("parked output not low/low");
    start_rise_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        $rose(on_q) |-> $past(g.rise) && $past(g.en) && true_q)
        else $error("gate opened off a rising edge");
    stop_fall_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        $fell(on_q) |-> $past(g.park) || ($past(g.fall) && !$past(g.en)))
        else $error("gate closed mid high phase");
endmodule

/* File: hdl/cmogl_top.sv */
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// - Loss is judged only from edges seen on the selected input clock.
// - Loss drives the open-drain indicator low and sets the event flag.
// - Indicator stays asserted from reset until a valid selected clock appears.
// - Only the selected input affects the indicator; the other is ignored.
// - After loss, outputs are parked with true and complement both low.
// - Output runs only when management bit, pin and side-band bit all enable.
// - Enabling and disabling are synchronous and free of runts and glitches.
// - One management enable bit per output, set to one after reset.
// - Writing zero parks the output low/low; writing one restarts it cleanly.
// - Enable pin low enables its output.
// - Enable pin high stops its output low/low, synchronously and glitch-free.
// - Enable changes act only on edges of the running input clock.
// - Each input has its own self-bias and termination enable bit.
// - Per-input sticky loss flags, cleared by writing one, zero leaves them.
// - Side-band bit one enables its output, zero disables it.
module cmogl_top #(
    parameter int NUM_OUT = cmogl_pkg::NUM_OUT,
    parameter int LOS_CYC = cmogl_pkg::LOS_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [cmogl_pkg::APB_AW-1:0] i_paddr,
    input wire logic [cmogl_pkg::APB_DW-1:0] i_pwdata,
    output logic [cmogl_pkg::APB_DW-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [cmogl_pkg::NUM_IN-1:0] i_ref_clock_in,
    input wire logic i_clk_sel,
    input wire logic [NUM_OUT-1:0] i_output_enable_n_pin,
    input wire logic [NUM_OUT-1:0] i_sideband_shift_en,
    output logic [NUM_OUT-1:0] o_clk_true,
    output logic [NUM_OUT-1:0] o_clk_comp,
    output logic o_loss_indicator_n_o,
    output logic o_loss_indicator_n_oe,
    output logic [cmogl_pkg::NUM_IN-1:0] o_input_selfbias_en,
    output logic [cmogl_pkg::NUM_IN-1:0] o_rx_term_en
);
    import cmogl_pkg::*;

    localparam int SIL_W = $clog2(LOS_CYC + 1);
    localparam int EDG_W = $clog2(VALID_EDGES + 1);
    localparam logic [SIL_W-1:0] SIL_MAX = SIL_W'(LOS_CYC);
    localparam logic [EDG_W-1:0] EDG_LAST = EDG_W'(VALID_EDGES - 1);

    // Registers
    logic [NUM_OUT-1:0] out_en_q;
    logic [NUM_IN-1:0] bias_q;
    logic [NUM_IN-1:0] term_q;
    logic [NUM_IN-1:0] evt_q;
    logic [APB_DW-1:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic loss_oe_q;

    // Input sampling and loss detector state
    logic [NUM_IN-1:0] ref_lvl_q;
    logic sel_q;
    logic sel_lvl_prev_q;
    logic [SIL_W-1:0] silence_q;
    logic [SIL_W-1:0] silence_d;
    logic [EDG_W-1:0] edges_q;
    logic [EDG_W-1:0] edges_d;
    cmogl_los_e los_q;
    cmogl_los_e los_d;

    // APB decode
    wire setup = i_psel && !i_penable;
    wire access = i_psel && i_penable && pready_q;
    wire wr = access && i_pwrite;
    wire hit_out_en = (i_paddr == ADDR_OUT_EN);
    wire hit_in_cfg = (i_paddr == ADDR_IN_CFG);
    wire hit_evt = (i_paddr == ADDR_LOSS_EVT);
    wire hit_stat = (i_paddr == ADDR_STATUS);
    wire hit_any = hit_out_en || hit_in_cfg || hit_evt || hit_stat;
    wire wr_out_en = wr && hit_out_en;
    wire wr_in_cfg = wr && hit_in_cfg;
    wire wr_evt = wr && hit_evt;

    // Selected clock edges; the unselected input never reaches the detector
    wire sel_lvl = ref_lvl_q[sel_q];
    wire sel_rise = sel_lvl && !sel_lvl_prev_q;
    wire sel_fall = !sel_lvl && sel_lvl_prev_q;
    wire sel_edge = sel_rise || sel_fall;
    wire sel_change = (i_clk_sel != sel_q);
    wire silent_out = (silence_q == SIL_MAX);
    wire loss_pulse = (los_q == CMOGL_VALID) && silent_out && !sel_change;
    wire park = (los_q != CMOGL_VALID);

    // Read data layout
    logic [APB_DW-1:0] rd_out_en;
    logic [APB_DW-1:0] rd_in_cfg;
    logic [APB_DW-1:0] rd_evt;
    logic [APB_DW-1:0] rd_stat;
    logic [APB_DW-1:0] rdata_d;

    assign rd_out_en = APB_DW'(out_en_q);
    assign rd_evt = APB_DW'({evt_q, {EVT_BIT0{1'b0}}});
    assign rd_stat = APB_DW'({sel_q, park}) << STAT_LOSS;
    assign rdata_d = hit_out_en ? rd_out_en :
                     hit_in_cfg ? rd_in_cfg :
                     hit_evt ? rd_evt :
                     hit_stat ? rd_stat : '0;

    // Answer one cycle after setup; unmapped addresses answer with an error
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && !hit_any;
            prdata_q <= setup ? rdata_d : '0;
        end
    end

    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_prdata = prdata_q;

    // Management enable bits, one per output, enabled after reset
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            out_en_q <= {NUM_OUT{OUT_EN_RST}};
        end else if (wr_out_en) begin
            out_en_q <= i_pwdata[NUM_OUT-1:0];
        end
    end

    // Per-input config bits and sticky loss flags
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_in
            wire evt_set = loss_pulse && (sel_q == 1'(gi));
            wire evt_clr = wr_evt && i_pwdata[EVT_BIT0 + gi];

            assign rd_in_cfg[CFG_TERM0 + gi*CFG_STRIDE] = term_q[gi];
            assign rd_in_cfg[CFG_BIAS0 + gi*CFG_STRIDE] = bias_q[gi];

            // Set wins over a clear in the same cycle
            always_ff @(posedge i_sys_clk) begin
                if (!i_nrst) begin
                    evt_q[gi] <= EVT_RST;
                end else begin
                    evt_q[gi] <= evt_set || (evt_q[gi] && !evt_clr);
                end
            end

            always_ff @(posedge i_sys_clk) begin
                if (!i_nrst) begin
                    term_q[gi] <= CFG_RST;
                    bias_q[gi] <= CFG_RST;
                end else if (wr_in_cfg) begin
                    term_q[gi] <= i_pwdata[CFG_TERM0 + gi*CFG_STRIDE];
                    bias_q[gi] <= i_pwdata[CFG_BIAS0 + gi*CFG_STRIDE];
                end
            end
        end
    endgenerate

    assign rd_in_cfg[APB_DW-1:NUM_IN*CFG_STRIDE] = '0;
    assign o_input_selfbias_en = bias_q;
    assign o_rx_term_en = term_q;

    // Silence and edge counters for the selected input
    assign silence_d = (sel_edge || sel_change) ? '0 :
                       silent_out ? silence_q : silence_q + 1'b1;
    // First edge after a silence still counts, so four edges always suffice
    assign edges_d = (sel_change || los_q == CMOGL_VALID) ? '0 :
                     sel_edge ? (silent_out ? EDG_W'(1) : edges_q + 1'b1) :
                     silent_out ? '0 : edges_q;

    // Loss detector: a new selection must prove itself before outputs run
    always_comb begin
        los_d = los_q;
        unique case (los_q)
            CMOGL_WAIT, CMOGL_LOST: begin
                if (!sel_change && sel_edge && edges_q == EDG_LAST && !silent_out) begin
                    los_d = CMOGL_VALID;
                end
            end
            CMOGL_VALID: begin
                if (sel_change) begin
                    los_d = CMOGL_WAIT;
                end else if (silent_out) begin
                    los_d = CMOGL_LOST;
                end
            end
            default: los_d = CMOGL_WAIT;
        endcase
        if (sel_change && los_q != CMOGL_VALID) begin
            los_d = CMOGL_WAIT;
        end
    end

    // Detector registers; indicator pulled low until a valid clock is seen
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            ref_lvl_q <= '0;
            sel_q <= 1'b0;
            sel_lvl_prev_q <= 1'b0;
            silence_q <= '0;
            edges_q <= '0;
            los_q <= CMOGL_WAIT;
            loss_oe_q <= 1'b1;
        end else begin
            ref_lvl_q <= i_ref_clock_in;
            sel_q <= i_clk_sel;
            sel_lvl_prev_q <= sel_change ? ref_lvl_q[i_clk_sel] : sel_lvl;
            silence_q <= silence_d;
            edges_q <= edges_d;
            los_q <= los_d;
            loss_oe_q <= (los_d != CMOGL_VALID);
        end
    end

    // Open-drain pin only ever pulls low
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_loss_indicator_n_o <= 1'b0;
        end else begin
            o_loss_indicator_n_o <= 1'b0;
        end
    end
    assign o_loss_indicator_n_oe = loss_oe_q;

    // One gate per output; enables are only acted on at input clock edges
    genvar go;
    generate
        for (go = 0; go < NUM_OUT; go++) begin : g_out
            cmogl_gate_if gif ();

            assign gif.clk_lvl = sel_lvl;
            assign gif.rise = sel_rise && !sel_change;
            assign gif.fall = sel_fall && !sel_change;
            assign gif.en = out_en_q[go]
                            && !i_output_enable_n_pin[go]
                            && i_sideband_shift_en[go];
            assign gif.park = park;

            cmogl_out_gate u_gate (
                .i_sys_clk(i_sys_clk),
                .i_nrst(i_nrst),
                .g(gif.gate)
            );

            assign o_clk_true[go] = gif.out_true;
            assign o_clk_comp[go] = gif.out_comp;
        end
    endgenerate

    flag_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (loss_pulse && !sel_q) |=> evt_q[0])
        else $error("loss event flag not set");
    flag_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (wr_evt && i_pwdata[EVT_BIT0] && !loss_pulse) |=> !evt_q[0])
        else $error("write one did not clear flag");
    flag_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (evt_q[1] && !(wr_evt && i_pwdata[EVT_BIT0 + 1])) |=> evt_q[1])
        else $error("sticky flag dropped");
    loss_timeout_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (los_q == CMOGL_VALID && silent_out && !sel_change) |=> los_q == CMOGL_LOST
            ##0 o_loss_indicator_n_oe)
        else $error("silence not declared loss");
    indicator_state_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        o_loss_indicator_n_oe == (los_q != CMOGL_VALID))
        else $error("indicator disagrees with detector");
    out_en_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        wr_out_en |=> out_en_q == $past(i_pwdata[NUM_OUT-1:0]))
        else $error("enable bits not written");
    cfg_pins_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        wr_in_cfg |=> o_rx_term_en[0] == $past(i_pwdata[CFG_TERM0])
            && o_input_selfbias_en[1] == $past(i_pwdata[CFG_BIAS0 + CFG_STRIDE]))
        else $error("config bits not on pins");
    apb_answer_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        setup |=> o_pready ##1 !o_pready)
        else $error("answer not one cycle after setup");
    unmapped_err_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (setup && !hit_any) |=> o_pslverr && o_prdata == '0)
        else $error("unmapped access not refused");
    parked_outputs_a: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        park [*2] |-> o_clk_true == '0 && o_clk_comp == '0)
        else $error("outputs not parked low/low");
endmodule

/* File: testbench/cmogl_clk_src.sv */
`timescale 1ns/1ps
// Far-side reference clocks: input 0 halves every 2 cycles, input 1 every 3
// A stopped source freezes at its last level, as a dead oscillator would
module cmogl_clk_src (
    input wire logic i_sys_clk,
    input wire logic [1:0] i_run,
    output logic [1:0] o_ref
);
    int cnt [2] = '{0, 0};
    initial o_ref = 2'b00;
    // Distinct rates so a wrong selection shows up as a wrong pulse width
    always @(posedge i_sys_clk) begin
        for (int k = 0; k < 2; k++) begin
            if (i_run[k]) begin
                cnt[k] <= (cnt[k] >= k + 1) ? 0 : cnt[k] + 1;
                if (cnt[k] >= k + 1) o_ref[k] <= ~o_ref[k];
            end
        end
    end
endmodule

/* File: testbench/cmogl_top_tb_top.sv */
`timescale 1ns/1ps
module cmogl_top_tb_top;
    import cmogl_pkg::*;
    localparam int LOS = 8;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, clk_sel, los_o, los_oe;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, seed;
    logic [1:0] ref_clk, run, bias, term;
    logic [3:0] oe_n, sb_en, clk_true, clk_comp;
    logic [33:0] exp_q [$];
    logic [33:0] e;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    // Open-drain indicator with its board pull-up
    wire los_n = los_oe ? los_o : 1'b1;

    cmogl_top #(.NUM_OUT(4), .LOS_CYC(LOS)) dut (
        .i_sys_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_ref_clock_in(ref_clk),
        .i_clk_sel(clk_sel), .i_output_enable_n_pin(oe_n), .i_sideband_shift_en(sb_en),
        .o_clk_true(clk_true), .o_clk_comp(clk_comp), .o_loss_indicator_n_o(los_o),
        .o_loss_indicator_n_oe(los_oe), .o_input_selfbias_en(bias), .o_rx_term_en(term));
    cmogl_clk_src src (.i_sys_clk(clk), .i_run(run), .o_ref(ref_clk));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic end_of_test();
        if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the note carries read flag, error flag and data
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic err, input logic [31:0] exp);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        exp_q.push_back({~wr, err, exp});
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Scoreboard: the oldest note is compared whenever the slave answers
    always @(posedge clk) begin
        if (pready === 1'b1) begin
            e = exp_q.pop_front();
            chk(32'(pslverr), 32'(e[32]));
            if (e[33]) chk(prdata, e[31:0]);
        end
    end

    // Hang guard, far above the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            error_cnt++;
            end_of_test();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Watch outputs: which ones pulse, and that every whole high phase is full while input 0 is selected
    task automatic watch(input logic [3:0] exp_run);
        int h [4];
        logic [3:0] prev;
        logic [3:0] ran;
        logic [3:0] cprev;
        logic [3:0] cran;
        h = '{0, 0, 0, 0};
        ran = 4'h0;
        cran = 4'h0;
        // A rise launched by the edge that carried the last enable change is legal
        @(posedge clk);
        prev = clk_true;
        cprev = clk_comp;
        repeat (48) begin
            @(posedge clk);
            chk(32'(clk_true & clk_comp), 32'h0);
            for (int i = 0; i < 4; i++) begin
                if (clk_true[i]) h[i]++;
                if (clk_true[i] && !prev[i]) ran[i] = 1'b1;
                if (clk_comp[i] && !cprev[i]) cran[i] = 1'b1;
                if (!clk_true[i] && prev[i]) begin
                    if (ran[i] && !clk_sel) chk(32'(h[i]), 32'h2);
                    h[i] = 0;
                end
            end
            prev = clk_true;
            cprev = clk_comp;
        end
        chk(32'(ran), 32'(exp_run));
        chk(32'(cran), 32'(exp_run));
    endtask

    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        clk_sel = 1'b0;
        oe_n = 4'h0;
        sb_en = 4'hf;
        run = 2'b00;
        seed = 32'hf276;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk(32'(los_n), 32'h0);
        apb(1'b0, ADDR_OUT_EN, 32'h0, 1'b0, 32'hf);
        apb(1'b0, ADDR_LOSS_EVT, 32'h0, 1'b0, 32'h0);
        // Status is read-only: a write answers cleanly and changes nothing
        apb(1'b1, ADDR_STATUS, 32'h3, 1'b0, 32'h0);
        apb(1'b0, ADDR_STATUS, 32'h0, 1'b0, 32'h1);
        apb(1'b0, 8'h10, 32'h0, 1'b1, 32'h0);
        apb(1'b1, 8'h02, 32'hffff, 1'b1, 32'h0);
        // Random input configuration, read back and seen at the pins
        repeat (3) begin
            seed = lfsr(seed);
            apb(1'b1, ADDR_IN_CFG, seed, 1'b0, 32'h0);
            apb(1'b0, ADDR_IN_CFG, 32'h0, 1'b0, seed & 32'hf);
            chk(32'({bias, term}), 32'({seed[3], seed[1], seed[2], seed[0]}));
        end
        // Only the unselected input runs: nothing may validate
        run <= 2'b10;
        repeat (30) @(posedge clk);
        chk(32'(los_n), 32'h0);
        watch(4'h0);
        run <= 2'b11;
        repeat (20) @(posedge clk);
        chk(32'(los_n), 32'h1);
        watch(4'hf);
        // One disable from each source, mid-phase
        apb(1'b1, ADDR_OUT_EN, 32'he, 1'b0, 32'h0);
        oe_n <= 4'b0010;
        sb_en <= 4'b1011;
        watch(4'h8);
        apb(1'b1, ADDR_OUT_EN, 32'hf, 1'b0, 32'h0);
        oe_n <= 4'h0;
        sb_en <= 4'hf;
        watch(4'hf);
        // Lose the selected input
        run <= 2'b10;
        repeat (LOS + 12) @(posedge clk);
        chk(32'(los_n), 32'h0);
        watch(4'h0);
        apb(1'b0, ADDR_LOSS_EVT, 32'h0, 1'b0, 32'h2);
        apb(1'b1, ADDR_LOSS_EVT, 32'h0, 1'b0, 32'h0);
        apb(1'b0, ADDR_LOSS_EVT, 32'h0, 1'b0, 32'h2);
        apb(1'b1, ADDR_LOSS_EVT, 32'h2, 1'b0, 32'h0);
        apb(1'b0, ADDR_LOSS_EVT, 32'h0, 1'b0, 32'h0);
        // Switch to the live input, then lose it too
        clk_sel <= 1'b1;
        repeat (30) @(posedge clk);
        chk(32'(los_n), 32'h1);
        apb(1'b0, ADDR_STATUS, 32'h0, 1'b0, 32'h2);
        run <= 2'b00;
        repeat (LOS + 12) @(posedge clk);
        apb(1'b0, ADDR_LOSS_EVT, 32'h0, 1'b0, 32'h4);
        // Reset in mid-run brings back indicator, enables and flags
        apb(1'b1, ADDR_OUT_EN, 32'h5, 1'b0, 32'h0);
        apb(1'b0, ADDR_OUT_EN, 32'h0, 1'b0, 32'h5);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk(32'(los_n), 32'h0);
        apb(1'b0, ADDR_OUT_EN, 32'h0, 1'b0, 32'hf);
        apb(1'b0, ADDR_LOSS_EVT, 32'h0, 1'b0, 32'h0);
        repeat (4) @(posedge clk);
        end_of_test();
    end
endmodule
